// *** hw/asc_defines.svh ***
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH
// control byte field positions
`define ASC_CB_START      7
`define ASC_CB_SEL_HI     6
`define ASC_CB_SEL_LO     4
`define ASC_CB_CLKSRC     3
`define ASC_CB_REFSRC     2
`define ASC_CB_REFPWR     1
`define ASC_CB_PWR        0
// serial clock falling-edge numbers counted from the start bit
`define ASC_FALL_TRACK    4'h4
`define ASC_FALL_HOLD_EXT 4'h6
`define ASC_FALL_HOLD_INT 4'h8
`define ASC_BYTE_BITS     4'h8
// falls after the result MSB before a new start bit is accepted
`define ASC_REHUNT_EXT    4'h2
`define ASC_REHUNT_INT    4'h3
`define ASC_LAST_SHIFT    4'h6
// timing
`define ASC_SYS_CLK_NS    4
`define ASC_INT_CONV_NS   35000
`define ASC_INT_CONV_CYC  (`ASC_INT_CONV_NS / `ASC_SYS_CLK_NS)
// host register map (byte addresses) and reset values
`define ASC_REG_CTRL      8'h00
`define ASC_REG_STATUS    8'h04
`define ASC_REG_RESULT    8'h08
`define ASC_REG_CLKDIV    8'h0C
`define ASC_CLKDIV_RST    16'h00FA
// floor of 64 cycles keeps the serial clock at or below 2 MHz
`define ASC_CLKDIV_MIN    16'h0040
`endif

// *** hw/asc_pkg.sv ***
package asc_pkg;
  typedef enum logic [2:0] {
    DEV_IDLE     = 3'b000,
    DEV_RX       = 3'b001,
    DEV_EXT_CONV = 3'b010,
    DEV_INT_ARM  = 3'b011,
    DEV_INT_CONV = 3'b100,
    DEV_OUT      = 3'b101
  } asc_dev_state_t;

  typedef enum logic [2:0] {
    HST_IDLE = 3'b000,
    HST_LEAD = 3'b001,
    HST_XFER = 3'b010,
    HST_WAIT = 3'b011,
    HST_TAIL = 3'b100
  } asc_host_state_t;
endpackage : asc_pkg

// *** hw/asc_link_if.sv ***
interface asc_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  wire  dout_wire;

  // a released line reads as the inverse of the last level, so a late sample shows up
  assign dout_wire = dout_oe ? dout : ~dout;

  modport device (
    input  cs_n,
    input  sclk,
    input  din,
    output dout,
    output dout_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output din,
    input  dout_wire
  );
endinterface : asc_link_if

// *** hw/asc_sync.sv ***
module asc_sync (
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic sys_rst_in,
  // async pin
  input  wire logic pin_in,
  // synchronised level and edges
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta_q;
  logic meta_d;
  logic lvl_q;
  logic lvl_d;
  logic prev_q;
  logic prev_d;

  always_comb begin
    meta_d = pin_in;
    lvl_d  = meta_q;
    prev_d = lvl_q;
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      meta_q <= 1'b0;
      lvl_q  <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      lvl_q  <= lvl_d;
      prev_q <= prev_d;
    end
  end

  assign level_out = lvl_q;
  assign rise_out  = lvl_q & ~prev_q;
  assign fall_out  = ~lvl_q & prev_q;
endmodule : asc_sync

// *** hw/asc_device.sv ***
// Notes on behaviour
// - capture one bit each rising clock, select low
// - result leaves MSB first; host samples rising
// - unipolar straight binary, bipolar twos complement
// - output floats when deselected, low on select
// - host clock limits while reading during conversion
// - leading zeros ignored; first one starts byte
// - seven more bits complete the control byte
// - bits six to four select inputs, polarity
// - bit three chooses conversion clock source
// - bit two chooses internal or external reference
// - bit one powers reference; needs bit zero (output here follows bit one alone)
// - bit zero powers converter; both zero off
// - external mode clock kept 50 to 500 kHz; host divider allows any rate up to 2 MHz
// - external: track at fall four, hold six
// - host serial port idles low, mode zero
// - serial clock always shifts data both modes
// - two byte transfers complete one conversion
// - external: MSB at fall eight, then zeros
// - internal: convert from fall eight, 35 us
// - external: deselect aborts, next one restarts
// - selector zero picks half supply input
`include "asc_defines.svh"
module asc_device #(
  parameter int INT_CONV_CYCLES = `ASC_INT_CONV_CYC
) (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  // serial link
  asc_link_if.device      link,
  // analog core
  input  wire logic [7:0] sar_code_in,
  output logic [2:0]      input_select_out,
  output logic            bipolar_out,
  output logic            vdd_half_select_out,
  output logic            conv_clock_source_out,
  output logic            reference_source_out,
  output logic            reference_power_on_out,
  output logic            converter_power_on_out,
  output logic            track_out,
  output logic            converting_out
);
  // raw core code is offset binary; bipolar flips the sign bit
  function automatic logic is_bipolar(input logic [2:0] sel);
    return (sel[2] == 1'b0) && (sel != 3'h0);
  endfunction : is_bipolar

  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  // select enters inverted so the synchroniser's reset level reads as deselected;
  // otherwise every reset would be followed by a phantom frame and a driven output
  logic [2:0] pin_raw;
  assign pin_raw = {link.din, link.sclk, ~link.cs_n};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      asc_sync u_sync (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (pin_raw[g]),
        .level_out  (pin_lvl[g]),
        .rise_out   (pin_rise[g]),
        .fall_out   (pin_fall[g])
      );
    end
  endgenerate

  logic sel_on;
  logic sclk_up;
  logic sclk_dn;
  logic din_lvl;
  assign sel_on  = pin_lvl[0];
  assign sclk_up = sel_on & pin_rise[1];
  assign sclk_dn = sel_on & pin_fall[1];
  assign din_lvl = pin_lvl[2];

  asc_pkg::asc_dev_state_t st_q, st_d;
  logic [7:0]  rx_q, rx_d;
  logic [3:0]  rxn_q, rxn_d;
  logic [3:0]  fcnt_q, fcnt_d;
  logic [7:0]  cfg_q, cfg_d;
  logic [7:0]  code_q, code_d;
  logic [7:0]  out_q, out_d;
  logic [3:0]  ocnt_q, ocnt_d;
  logic [13:0] tmr_q, tmr_d;
  logic        track_q, track_d;
  logic        conv_q, conv_d;
  logic        oe_q, oe_d;
  logic        bip_q, bip_d;
  logic        vdd_q, vdd_d;

  logic [7:0] byte_new;
  logic [7:0] result;
  logic       ext_mode;
  logic       hunt;
  assign byte_new = {rx_q[6:0], din_lvl};
  assign ext_mode = cfg_q[`ASC_CB_CLKSRC];
  assign result   = is_bipolar(cfg_q[`ASC_CB_SEL_HI:`ASC_CB_SEL_LO]) ?
                    {~code_q[7], code_q[6:0]} : code_q;

  always_comb begin
    st_d    = st_q;
    rx_d    = rx_q;
    rxn_d   = rxn_q;
    fcnt_d  = fcnt_q;
    cfg_d   = cfg_q;
    code_d  = code_q;
    out_d   = out_q;
    ocnt_d  = ocnt_q;
    tmr_d   = tmr_q;
    track_d = track_q;
    conv_d  = conv_q;
    bip_d   = bip_q;
    vdd_d   = vdd_q;
    oe_d    = sel_on;
    // a new start bit may overlap the tail of the previous result
    hunt = (st_q == asc_pkg::DEV_IDLE) ||
           ((st_q == asc_pkg::DEV_OUT) &&
            (ocnt_q >= (ext_mode ? `ASC_REHUNT_EXT : `ASC_REHUNT_INT)));
    if (pin_rise[0] && (st_q == asc_pkg::DEV_IDLE)) begin
      out_d = 8'h00;
    end
    if (sclk_up) begin
      if (st_q == asc_pkg::DEV_RX) begin
        rx_d  = byte_new;
        rxn_d = rxn_q + 4'h1;
        if (rxn_q == (`ASC_BYTE_BITS - 4'h1)) begin
          cfg_d = byte_new;
          bip_d = is_bipolar(byte_new[`ASC_CB_SEL_HI:`ASC_CB_SEL_LO]);
          vdd_d = (byte_new[`ASC_CB_SEL_HI:`ASC_CB_SEL_LO] == 3'h0);
          st_d  = byte_new[`ASC_CB_CLKSRC] ? asc_pkg::DEV_EXT_CONV
                                            : asc_pkg::DEV_INT_ARM;
        end
      end else if (hunt && din_lvl) begin
        st_d   = asc_pkg::DEV_RX;
        rx_d   = 8'h01;
        rxn_d  = 4'h1;
        fcnt_d = 4'h0;
      end
    end
    if (sclk_dn) begin
      if (fcnt_q != 4'hF) begin
        fcnt_d = fcnt_q + 4'h1;
      end
      out_d = {out_q[6:0], 1'b0};
      case (st_q)
        asc_pkg::DEV_RX: begin
          if (fcnt_q == (`ASC_FALL_TRACK - 4'h1)) begin
            track_d = 1'b1;
          end
          // bit three sits at rx_q[1] once six bits are in
          if ((fcnt_q == (`ASC_FALL_HOLD_EXT - 4'h1)) && rx_q[1]) begin
            track_d = 1'b0;
            conv_d  = 1'b1;
            code_d  = sar_code_in;
          end
        end
        asc_pkg::DEV_EXT_CONV: begin
          out_d  = result;
          ocnt_d = 4'h0;
          st_d   = asc_pkg::DEV_OUT;
        end
        asc_pkg::DEV_INT_ARM: begin
          track_d = 1'b0;
          conv_d  = 1'b1;
          code_d  = sar_code_in;
          tmr_d   = 14'h0000;
          st_d    = asc_pkg::DEV_INT_CONV;
        end
        asc_pkg::DEV_OUT: begin
          ocnt_d = ocnt_q + 4'h1;
          if (ocnt_q == `ASC_LAST_SHIFT) begin
            conv_d = 1'b0;
            st_d   = asc_pkg::DEV_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
    // internal conversion runs on its own timer, select or not
    if (st_q == asc_pkg::DEV_INT_CONV) begin
      tmr_d = tmr_q + 14'h0001;
      if (tmr_q == 14'(INT_CONV_CYCLES - 1)) begin
        out_d  = result;
        ocnt_d = 4'h0;
        conv_d = 1'b0;
        st_d   = asc_pkg::DEV_OUT;
      end
    end
    if (pin_fall[0] && (st_q != asc_pkg::DEV_INT_CONV)) begin
      st_d    = asc_pkg::DEV_IDLE;
      conv_d  = 1'b0;
      track_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st_q    <= asc_pkg::DEV_IDLE;
      rx_q    <= 8'h00;
      rxn_q   <= 4'h0;
      fcnt_q  <= 4'h0;
      cfg_q   <= 8'h00;
      code_q  <= 8'h00;
      out_q   <= 8'h00;
      ocnt_q  <= 4'h0;
      tmr_q   <= 14'h0000;
      track_q <= 1'b0;
      conv_q  <= 1'b0;
      oe_q    <= 1'b0;
      bip_q   <= 1'b0;
      vdd_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      rx_q    <= rx_d;
      rxn_q   <= rxn_d;
      fcnt_q  <= fcnt_d;
      cfg_q   <= cfg_d;
      code_q  <= code_d;
      out_q   <= out_d;
      ocnt_q  <= ocnt_d;
      tmr_q   <= tmr_d;
      track_q <= track_d;
      conv_q  <= conv_d;
      oe_q    <= oe_d;
      bip_q   <= bip_d;
      vdd_q   <= vdd_d;
    end
  end

  assign link.dout              = out_q[7];
  assign link.dout_oe           = oe_q;
  assign input_select_out       = cfg_q[`ASC_CB_SEL_HI:`ASC_CB_SEL_LO];
  assign bipolar_out            = bip_q;
  assign vdd_half_select_out    = vdd_q;
  assign conv_clock_source_out  = cfg_q[`ASC_CB_CLKSRC];
  assign reference_source_out   = cfg_q[`ASC_CB_REFSRC];
  assign reference_power_on_out = cfg_q[`ASC_CB_REFPWR];
  assign converter_power_on_out = cfg_q[`ASC_CB_PWR];
  assign track_out              = track_q;
  assign converting_out         = conv_q;
endmodule : asc_device

// *** hw/asc_host.sv ***
`include "asc_defines.svh"
module asc_host #(
  parameter int INT_WAIT_CYCLES = `ASC_INT_CONV_CYC
) (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link
  asc_link_if.host         link
);
  logic dout_lvl;

  asc_sync u_dout_sync (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (link.dout_wire),
    .level_out  (dout_lvl),
    .rise_out   (),
    .fall_out   ()
  );

  asc_pkg::asc_host_state_t st_q, st_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  tx_q, tx_d;
  logic [7:0]  res_q, res_d;
  logic [15:0] div_q, div_d;
  logic [15:0] hcnt_q, hcnt_d;
  logic [13:0] wait_q, wait_d;
  logic [4:0]  bit_q, bit_d;
  logic        cs_n_q, cs_n_d;
  logic        sclk_q, sclk_d;
  logic        done_q, done_d;
  logic [31:0] rd_q, rd_d;
  logic        rdy_q, rdy_d;
  logic        err_q, err_d;

  logic access;
  logic half_up;
  logic ext_mode;
  assign access   = psel & penable & ~rdy_q;
  assign half_up  = (hcnt_q == div_q - 16'h0001);
  assign ext_mode = ctrl_q[`ASC_CB_CLKSRC];

  always_comb begin
    st_d   = st_q;
    ctrl_d = ctrl_q;
    tx_d   = tx_q;
    res_d  = res_q;
    div_d  = div_q;
    hcnt_d = half_up ? 16'h0000 : hcnt_q + 16'h0001;
    wait_d = wait_q;
    bit_d  = bit_q;
    cs_n_d = cs_n_q;
    sclk_d = sclk_q;
    done_d = done_q;
    rd_d   = rd_q;
    rdy_d  = access;
    err_d  = 1'b0;
    if (access) begin
      if (paddr == `ASC_REG_CTRL) begin
        rd_d = {24'h000000, ctrl_q};
        // a new order is ignored while a transfer runs
        if (pwrite && (st_q == asc_pkg::HST_IDLE)) begin
          ctrl_d = pwdata[7:0];
          tx_d   = pwdata[7:0];
          done_d = 1'b0;
          hcnt_d = 16'h0000;
          bit_d  = 5'h00;
          cs_n_d = 1'b0;
          st_d   = asc_pkg::HST_LEAD;
        end
      end else if (paddr == `ASC_REG_STATUS) begin
        rd_d = {30'h0, done_q, (st_q != asc_pkg::HST_IDLE)};
      end else if (paddr == `ASC_REG_RESULT) begin
        rd_d = {24'h000000, res_q};
      end else if (paddr == `ASC_REG_CLKDIV) begin
        rd_d = {16'h0000, div_q};
        if (pwrite && (st_q == asc_pkg::HST_IDLE)) begin
          // the floor keeps the serial clock at or below 2 MHz
          div_d = (pwdata[15:0] < `ASC_CLKDIV_MIN) ? `ASC_CLKDIV_MIN : pwdata[15:0];
        end
      end else begin
        rd_d  = 32'h00000000;
        err_d = 1'b1;
      end
    end
    case (st_q)
      asc_pkg::HST_LEAD: begin
        if (half_up) begin
          st_d = asc_pkg::HST_XFER;
        end
      end
      asc_pkg::HST_XFER: begin
        if (half_up) begin
          sclk_d = ~sclk_q;
          if (!sclk_q) begin
            if (bit_q >= 5'h08) begin
              res_d = {res_q[6:0], dout_lvl};
            end
          end else begin
            tx_d  = {tx_q[6:0], 1'b0};
            bit_d = bit_q + 5'h01;
            if ((bit_q == 5'h07) && !ext_mode) begin
              wait_d = 14'h0000;
              st_d   = asc_pkg::HST_WAIT;
            end else if (bit_q == 5'h0F) begin
              st_d = asc_pkg::HST_TAIL;
            end
          end
        end
      end
      asc_pkg::HST_WAIT: begin
        wait_d = wait_q + 14'h0001;
        if (wait_q == 14'(INT_WAIT_CYCLES)) begin
          hcnt_d = 16'h0000;
          st_d   = asc_pkg::HST_XFER;
        end
      end
      asc_pkg::HST_TAIL: begin
        if (half_up) begin
          cs_n_d = 1'b1;
          done_d = 1'b1;
          st_d   = asc_pkg::HST_IDLE;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st_q   <= asc_pkg::HST_IDLE;
      ctrl_q <= 8'h00;
      tx_q   <= 8'h00;
      res_q  <= 8'h00;
      div_q  <= `ASC_CLKDIV_RST;
      hcnt_q <= 16'h0000;
      wait_q <= 14'h0000;
      bit_q  <= 5'h00;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      done_q <= 1'b0;
      rd_q   <= 32'h00000000;
      rdy_q  <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      ctrl_q <= ctrl_d;
      tx_q   <= tx_d;
      res_q  <= res_d;
      div_q  <= div_d;
      hcnt_q <= hcnt_d;
      wait_q <= wait_d;
      bit_q  <= bit_d;
      cs_n_q <= cs_n_d;
      sclk_q <= sclk_d;
      done_q <= done_d;
      rd_q   <= rd_d;
      rdy_q  <= rdy_d;
      err_q  <= err_d;
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.din  = tx_q[7]; // bits past the byte go out as zeros
  assign prdata    = rd_q;
  assign pready    = rdy_q;
  assign pslverr   = err_q;
endmodule : asc_host

// *** testbench/asc_link_asserts.sv ***
module asc_link_asserts (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // link signals
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  logic       sclk_q;
  logic [4:0] rises_q;
  logic [4:0] rises_d;
  logic [4:0] falls_q;
  logic [4:0] falls_d;
  logic [3:0] gap_q;
  logic [3:0] gap_d;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  // rise and fall counts restart with every frame so one frame never borrows edges of another
  always_comb begin
    rises_d = cs_n ? 5'h00 : rises_q + {4'h0, sclk & ~sclk_q};
    falls_d = cs_n ? 5'h00 : falls_q + {4'h0, sclk_q & ~sclk};
    gap_d   = (sclk_q & ~sclk) ? 4'h0 : gap_q + {3'h0, gap_q != 4'hF};
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sclk_q  <= 1'b0;
      rises_q <= 5'h00;
      falls_q <= 5'h00;
      gap_q   <= 4'hF;
    end else begin
      sclk_q  <= sclk;
      rises_q <= rises_d;
      falls_q <= falls_d;
      gap_q   <= gap_d;
    end
  end

  sequence frame_open_s;
    $fell(cs_n);
  endsequence

  sequence drive_low_s;
    dout_oe && !dout;
  endsequence

  idle_low_a: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  din_launch_a: assert property ($changed(din) |-> !sclk)
    else $error("data in changed while clock high");
  select_edge_a: assert property (frame_open_s |-> !sclk)
    else $error("select fell with clock high");
  oe_off_a: assert property (cs_n [*5] |-> !dout_oe)
    else $error("data out driven while deselected");
  oe_on_a: assert property (frame_open_s |-> ##[2:5] drive_low_s)
    else $error("data out not driven low after select");
  out_stable_a: assert property ($rose(sclk) && !cs_n |-> $stable(dout) [*6])
    else $error("data out moved around clock rise");
  rise_count_a: assert property ($rose(cs_n) |-> rises_q == 5'h10)
    else $error("frame without sixteen clock rises");
  tail_zero_a: assert property (falls_q == 5'h10 && gap_q == 4'h8 && !cs_n |-> !dout)
    else $error("data out not zero after last bit");
endmodule : asc_link_asserts

// *** testbench/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk_in  = 1'b0;
  logic        sys_rst_in  = 1'b1;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [7:0]  paddr       = 8'h00;
  logic [31:0] pwdata      = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  sar_code    = 8'h00;
  logic [2:0]  sel_o;
  logic [5:0]  cfg_o;
  logic [1:0]  act_o;
  logic [15:0] din_cap     = 16'h0;
  logic [15:0] dout_cap    = 16'h0;
  int          fails       = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  logic        sclk_p      = 1'b0;
  logic [1:0]  act_p       = 2'b00;
  logic [4:0]  falls       = 5'h00;
  logic [4:0]  trk_at      = 5'h00;
  logic [4:0]  cnv_at      = 5'h00;

  asc_link_if link ();

  asc_host #(.INT_WAIT_CYCLES(220)) asc_host_i (
    .sys_clk_in, .sys_rst_in, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .link(link));

  asc_device #(.INT_CONV_CYCLES(200)) asc_device_i (
    .sys_clk_in, .sys_rst_in, .link(link), .sar_code_in(sar_code),
    .input_select_out(sel_o), .bipolar_out(cfg_o[5]), .vdd_half_select_out(cfg_o[4]),
    .conv_clock_source_out(cfg_o[3]), .reference_source_out(cfg_o[2]),
    .reference_power_on_out(cfg_o[1]), .converter_power_on_out(cfg_o[0]),
    .track_out(act_o[1]), .converting_out(act_o[0]));

  asc_link_asserts asc_link_asserts_i (
    .sys_clk_in, .sys_rst_in, .cs_n(link.cs_n), .sclk(link.sclk), .din(link.din),
    .dout(link.dout), .dout_oe(link.dout_oe));

  always #2 sys_clk_in = ~sys_clk_in;

  // the wire is sampled where the host samples it, on the clock rise
  always @(posedge link.sclk) begin
    if (!link.cs_n) begin
      din_cap  <= {din_cap[14:0], link.din};
      dout_cap <= {dout_cap[14:0], link.dout_wire};
    end
  end

  // serial clock falls in the frame, and where tracking and conversion begin among them
  always @(posedge sys_clk_in) begin
    sclk_p <= link.sclk;
    act_p  <= act_o;
    if (link.cs_n) begin
      falls <= 5'h00;
    end else if (sclk_p && !link.sclk) begin
      falls <= falls + 5'h01;
    end
    if (act_o[1] && !act_p[1]) begin
      trk_at <= falls;
    end
    if (act_o[0] && !act_p[0]) begin
      cnv_at <= falls;
    end
  end

  // eight frames at 500 kHz take about 68000 cycles, three fast ones about 7200
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 90000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk

  // one idle cycle after each transfer keeps back-to-back calls from double driving
  task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    do @(posedge sys_clk_in); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk_in);
  endtask : apb_xfer

  task automatic test_regs;
    logic [31:0] r;
    logic        e;
    chk("idle pins", {link.cs_n, link.sclk}, 2'b10);
    chk("dout released", link.dout_oe, 1'b0);
    apb_xfer(1'b0, 8'h0C, 32'h0, r, e);
    chk("clkdiv reset", r, 32'h0000_00FA);
    apb_xfer(1'b0, 8'h04, 32'h0, r, e);
    chk("status reset", r, 32'h0);
    apb_xfer(1'b0, 8'h10, 32'h0, r, e);
    chk("unmapped", {r[30:0], e}, 32'h1);
    apb_xfer(1'b1, 8'h0C, 32'h5, r, e);
    apb_xfer(1'b0, 8'h0C, 32'h0, r, e);
    chk("clkdiv floor", r, 32'h40);
    $display("test_regs done");
  endtask : test_regs

  // a second control write while busy must be ignored by the host
  task automatic run_conv(input logic [7:0] cb, input logic [7:0] code);
    logic [31:0] r;
    logic        e;
    logic [7:0]  exp;
    exp = (cb[6:4] inside {3'b001, 3'b010, 3'b011}) ? {~code[7], code[6:0]} : code;
    sar_code <= code;
    apb_xfer(1'b1, 8'h00, {24'h0, cb}, r, e);
    apb_xfer(1'b1, 8'h00, 32'h80, r, e);
    // this wait ends when the status done bit reads one, or else at the bench timeout
    do begin
      apb_xfer(1'b0, 8'h04, 32'h0, r, e);
    end while (r[1] !== 1'b1);
    apb_xfer(1'b0, 8'h08, 32'h0, r, e);
    chk("result reg", r, {24'h0, exp});
    chk("result wire", dout_cap[7:0], exp);
    chk("control wire", din_cap[15:8], cb);
    chk("config", {sel_o, cfg_o[3:0]}, cb[6:0]);
    chk("polarity", cfg_o[5:4], {exp != code, cb[6:4] == 3'b000});
    chk("converting", act_o[0], 1'b0);
    chk("track edge", trk_at, 5'h04);
    chk("hold edge", cnv_at, cb[3] ? 5'h06 : 5'h08);
  endtask : run_conv

  task automatic test_ext;
    logic [3:0]  s;
    logic [31:0] r;
    logic        e;
    apb_xfer(1'b1, 8'h0C, 32'hFA, r, e);
    for (s = 4'h0; s < 4'h8; s++) begin
      run_conv({1'b1, s[2:0], 1'b1, s[1], s[0] & s[2], s[2]}, 8'h96 ^ {s, s});
    end
    $display("test_ext done");
  endtask : test_ext

  task automatic test_int;
    logic [31:0] r;
    logic        e;
    apb_xfer(1'b1, 8'h0C, 32'h40, r, e);
    run_conv(8'hF7, 8'h5A);
    run_conv(8'h83, 8'hFF);
    run_conv(8'hB5, 8'h01);
    $display("test_int done");
  endtask : test_int

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (5) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    test_regs();
    test_ext();
    test_int();
    stop_test();
  end
endmodule : testbench
